/* rtl/serdes_tx_lane_consts.svh */
`ifndef SERDES_TX_LANE_CONSTS_SVH
`define SERDES_TX_LANE_CONSTS_SVH

// register map
`define CFG_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define CFG_RESET 32'h0000_0000
`define CFG_WRITE_MASK 32'h0001_fffd

// status bit positions
`define STAT_RETURN_LEVEL 0
`define STAT_PHASE_ERR 1
`define STAT_ILLEGAL_CFG 2

// width and rate codes
`define WIDTH_TEN 3'h0
`define WIDTH_EIGHT 3'h1
`define RATE_FULL 2'h0
`define RATE_HALF 2'h1
`define RATE_QUARTER 2'h2
`define RATE_RESERVED 2'h3

// sys_clk cycles per bit, minus one (one cycle stands for half a pll cycle)
`define DIV_FULL 2'h0
`define DIV_HALF 2'h1
`define DIV_QUARTER 2'h3

// bit index figures of the byte clock
`define LAST_BIT_TEN 4'h9
`define LAST_BIT_EIGHT 4'h7
`define BYTE_CLK_HIGH_BITS 4'h4

// output swing in mv per code
`define SWING_MV_0 11'h07d
`define SWING_MV_1 11'h0fa
`define SWING_MV_2 11'h1f4
`define SWING_MV_3 11'h271
`define SWING_MV_4 11'h2ee
`define SWING_MV_5 11'h3e8
`define SWING_MV_6 11'h465
`define SWING_MV_7 11'h4e2

// de-emphasis in hundredths of a percent: code * 10000 / 21
`define EMPH_SCALE 18'h02710
`define EMPH_STEPS 18'h00015
`define EMPH_MAX_HUNDREDTHS 14'h1be6

// common mode raise, percent of reference level
`define CM_RAISE_PERCENT 8'h05

`endif

/* rtl/serdes_tx_lane_pkg.sv */
`default_nettype none
package serdes_tx_lane_pkg;

  // configuration word, bit 31 first
  typedef struct packed {
    logic [14:0] reserved_hi;
    logic fixed_phase_select;
    logic [3:0] tx_emphasis_reduction;
    logic [2:0] swing;
    logic common_level_raise;
    logic pair_polarity_swap;
    logic [1:0] rate;
    logic [2:0] parallel_width_select;
    logic reserved_lo;
    logic transmitter_on;
  } cfg_s;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } bus_req_s;

  // analogue settings toward the driver
  typedef struct packed {
    logic [10:0] swing_mv;
    logic [13:0] emph_hundredths;
    logic cm_raise;
  } analog_s;

  // serializer state
  typedef struct packed {
    logic [1:0] div;
    logic [3:0] idx;
    logic [9:0] shreg;
    logic bit_q;
    logic byte_clk;
    logic taken;
  } ser_state_s;

  // lane top state
  typedef struct packed {
    cfg_s cfg;
    logic [31:0] rd_data;
    logic ret_s1;
    logic ret_s2;
    logic clk_d1;
    logic clk_d2;
    logic phase_err;
    logic pos;
    logic neg;
    analog_s analog;
  } lane_state_s;

endpackage
`default_nettype wire

/* rtl/lane_serializer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "serdes_tx_lane_consts.svh"

module lane_serializer
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // settings
  input wire logic run_i,
  input wire logic width_eight_i,
  input wire logic [1:0] rate_i,
  // parallel side
  input wire logic [9:0] word_i,
  output logic word_taken_o,
  // serial side
  output logic serial_bit_o,
  output logic byte_clk_o
);
  import serdes_tx_lane_pkg::*;

  ser_state_s st;
  ser_state_s next_st;
  logic [1:0] limit;
  logic [3:0] last;
  logic [9:0] word;

  // bit period, word length and word alignment
  always_comb
  begin
    case (rate_i)
      `RATE_FULL: limit = `DIV_FULL;
      `RATE_HALF: limit = `DIV_HALF;
      default: limit = `DIV_QUARTER;
    endcase
    last = width_eight_i ? `LAST_BIT_EIGHT : `LAST_BIT_TEN;
    word = width_eight_i ? {2'h0, word_i[9:2]} : word_i;
  end

  // shift one bit per period, reload after the last bit
  always_comb
  begin
    next_st = st;
    next_st.taken = 1'b0;
    if (!run_i)
    begin
      next_st.div = 2'h0;
      next_st.idx = `LAST_BIT_TEN;
      next_st.bit_q = 1'b0;
      next_st.byte_clk = 1'b0;
    end
    else if (st.div >= limit)
    begin
      next_st.div = 2'h0;
      if (st.idx >= last)
      begin
        next_st.idx = 4'h0;
        next_st.bit_q = word[0];
        next_st.shreg = {1'b0, word[9:1]};
        next_st.taken = 1'b1;
      end
      else
      begin
        next_st.idx = st.idx + 4'h1;
        next_st.bit_q = st.shreg[0];
        next_st.shreg = {1'b0, st.shreg[9:1]};
      end
      next_st.byte_clk = (next_st.idx < `BYTE_CLK_HIGH_BITS);
    end
    else
    begin
      next_st.div = st.div + 2'h1;
    end
  end

  // state register
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      st <= '0;
      st.idx <= `LAST_BIT_TEN;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign serial_bit_o = st.bit_q;
  assign byte_clk_o = st.byte_clk;
  assign word_taken_o = st.taken;

endmodule // lane_serializer
`default_nettype wire

/* rtl/serdes_tx_lane_config.sv */
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "serdes_tx_lane_consts.svh"

module serdes_tx_lane_config
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // register port
  input wire serdes_tx_lane_pkg::bus_req_s bus_i,
  output logic [31:0] rd_data_o,
  // parallel data
  input wire logic [9:0] tx_parallel_word_i,
  output logic word_taken_o,
  // byte clock
  output logic tx_byte_clock_out_o,
  input wire logic tx_byte_clock_return_i,
  // differential pair and analogue settings
  output logic tx_pos_line_o,
  output logic tx_neg_line_o,
  output serdes_tx_lane_pkg::analog_s analog_o
);
  import serdes_tx_lane_pkg::*;

  lane_state_s st;
  lane_state_s next_st;
  logic legal;
  logic run;
  logic ser_bit;
  logic ser_byte_clk;
  logic ser_taken;
  logic [17:0] emph_prod;

  // reserved width or rate codes hold the lane idle
  assign legal = (st.cfg.parallel_width_select == `WIDTH_TEN ||
                  st.cfg.parallel_width_select == `WIDTH_EIGHT) &&
                 (st.cfg.rate != `RATE_RESERVED);
  assign run = st.cfg.transmitter_on && legal;

  // serializer
  lane_serializer u_ser
  (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .run_i(run),
    .width_eight_i(st.cfg.parallel_width_select == `WIDTH_EIGHT),
    .rate_i(st.cfg.rate),
    .word_i(tx_parallel_word_i),
    .word_taken_o(ser_taken),
    .serial_bit_o(ser_bit),
    .byte_clk_o(ser_byte_clk)
  );

  // register access, sync, polarity and analogue decode
  always_comb
  begin
    next_st = st;
    emph_prod = 18'(st.cfg.tx_emphasis_reduction) * `EMPH_SCALE;
    if (bus_i.wr && bus_i.addr == `CFG_OFFSET)
    begin
      next_st.cfg = cfg_s'(bus_i.wdata & `CFG_WRITE_MASK);
    end
    next_st.rd_data = 32'h0;
    if (bus_i.rd)
    begin
      case (bus_i.addr)
        `CFG_OFFSET: next_st.rd_data = st.cfg;
        `STATUS_OFFSET:
        begin
          next_st.rd_data[`STAT_RETURN_LEVEL] = st.ret_s2;
          next_st.rd_data[`STAT_PHASE_ERR] = st.phase_err;
          next_st.rd_data[`STAT_ILLEGAL_CFG] = !legal;
        end
        default: next_st.rd_data = 32'h0;
      endcase
    end
    // returned byte clock through two flops, compared to delayed out clock
    next_st.ret_s1 = tx_byte_clock_return_i;
    next_st.ret_s2 = st.ret_s1;
    next_st.clk_d1 = ser_byte_clk;
    next_st.clk_d2 = st.clk_d1;
    next_st.phase_err = st.cfg.fixed_phase_select && run &&
                        (st.ret_s2 != st.clk_d2);
    // pair polarity, both lines low while disabled
    next_st.pos = run && (ser_bit ^ st.cfg.pair_polarity_swap);
    next_st.neg = run && (!ser_bit ^ st.cfg.pair_polarity_swap);
    // analogue settings
    case (st.cfg.swing)
      3'h0: next_st.analog.swing_mv = `SWING_MV_0;
      3'h1: next_st.analog.swing_mv = `SWING_MV_1;
      3'h2: next_st.analog.swing_mv = `SWING_MV_2;
      3'h3: next_st.analog.swing_mv = `SWING_MV_3;
      3'h4: next_st.analog.swing_mv = `SWING_MV_4;
      3'h5: next_st.analog.swing_mv = `SWING_MV_5;
      3'h6: next_st.analog.swing_mv = `SWING_MV_6;
      default: next_st.analog.swing_mv = `SWING_MV_7;
    endcase
    next_st.analog.emph_hundredths = 14'(emph_prod / `EMPH_STEPS);
    next_st.analog.cm_raise = st.cfg.common_level_raise;
  end

  // state register
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      st <= '0;
      st.cfg <= cfg_s'(`CFG_RESET);
      st.analog.swing_mv <= `SWING_MV_0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign rd_data_o = st.rd_data;
  assign tx_pos_line_o = st.pos;
  assign tx_neg_line_o = st.neg;
  assign analog_o = st.analog;
  assign tx_byte_clock_out_o = ser_byte_clk;
  assign word_taken_o = ser_taken;

  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  sequence s_hi4;
    tx_byte_clock_out_o [*4];
  endsequence
  sequence s_lo6;
    !tx_byte_clock_out_o [*6];
  endsequence
  sequence s_lo4;
    !tx_byte_clock_out_o [*4];
  endsequence

  AST_TX_OFF_IDLE: assert property (!st.cfg.transmitter_on |=>
    !tx_pos_line_o && !tx_neg_line_o)
    else $error("lane drives pair while disabled");

  // frames cut short by a write or by a stopped lane are not judged
  AST_BYTE_CLK_TEN: assert property (disable iff (srst_i || bus_i.wr || !run)
    $rose(tx_byte_clock_out_o) && st.cfg.rate == `RATE_FULL &&
    st.cfg.parallel_width_select == `WIDTH_TEN |-> s_hi4 ##1 s_lo6)
    else $error("ten-bit byte clock not 4 high 6 low");

  AST_BYTE_CLK_EIGHT: assert property (disable iff (srst_i || bus_i.wr || !run)
    $rose(tx_byte_clock_out_o) && st.cfg.rate == `RATE_FULL &&
    st.cfg.parallel_width_select == `WIDTH_EIGHT |-> s_hi4 ##1 s_lo4)
    else $error("eight-bit byte clock not 4 high 4 low");

  AST_RATE_HALF: assert property (disable iff (srst_i || bus_i.wr || !run)
    word_taken_o && run && st.cfg.rate == `RATE_HALF &&
    st.cfg.parallel_width_select == `WIDTH_TEN |-> ##20 word_taken_o)
    else $error("half rate word spacing wrong");

  AST_RATE_RESERVED: assert property (st.cfg.rate == `RATE_RESERVED
    |=> !tx_byte_clock_out_o && !word_taken_o)
    else $error("reserved rate still runs the lane");

  AST_SWAP: assert property (run && st.cfg.pair_polarity_swap |=>
    tx_pos_line_o == !$past(ser_bit) && tx_neg_line_o == $past(ser_bit))
    else $error("pair polarity swap not applied");

  AST_PHASE_FREE: assert property (!st.cfg.fixed_phase_select |=>
    !st.phase_err)
    else $error("phase error flagged in arbitrary phase mode");

  AST_CM: assert property (st.cfg.common_level_raise |=>
    analog_o.cm_raise)
    else $error("common mode raise not passed on");

  AST_SWING: assert property (st.cfg.swing == 3'h7 |=>
    analog_o.swing_mv == `SWING_MV_7)
    else $error("top swing code wrong amplitude");

  AST_EMPH: assert property (st.cfg.tx_emphasis_reduction == 4'hf |=>
    analog_o.emph_hundredths == `EMPH_MAX_HUNDREDTHS)
    else $error("top de-emphasis code wrong value");

  AST_RSV_ZERO: assert property (bus_i.rd && bus_i.addr == `CFG_OFFSET
    |=> rd_data_o[31:17] == 15'h0 && !rd_data_o[1])
    else $error("reserved bits read nonzero");

  AST_TX_ON_ACTIVE: assert property (disable iff (srst_i || !run)
    run |-> ##[1:30] tx_byte_clock_out_o)
    else $error("enabled lane shows no byte clock");

  AST_WORD_TEN_FULL: assert property (disable iff (srst_i || bus_i.wr || !run)
    word_taken_o && st.cfg.rate == `RATE_FULL &&
    st.cfg.parallel_width_select == `WIDTH_TEN |-> ##10 word_taken_o)
    else $error("full rate ten-bit word spacing wrong");

  AST_WORD_EIGHT_QUARTER: assert property (disable iff (srst_i || bus_i.wr || !run)
    word_taken_o && st.cfg.rate == `RATE_QUARTER &&
    st.cfg.parallel_width_select == `WIDTH_EIGHT |-> ##32 word_taken_o)
    else $error("quarter rate eight-bit word spacing wrong");

  AST_POLARITY_NORMAL: assert property (run && !st.cfg.pair_polarity_swap |=>
    tx_pos_line_o == $past(ser_bit) && tx_neg_line_o == !$past(ser_bit))
    else $error("normal polarity not applied");

  AST_PHASE_FLAG: assert property (st.cfg.fixed_phase_select && run &&
    st.ret_s2 != st.clk_d2 |=> st.phase_err)
    else $error("fixed phase mismatch not flagged");

  AST_RSV_WRITE: assert property (bus_i.wr && bus_i.addr == `CFG_OFFSET |=>
    st.cfg.reserved_hi == 15'h0 && !st.cfg.reserved_lo)
    else $error("reserved bits stored on write");

endmodule // serdes_tx_lane_config
`default_nettype wire

/* test/lane_receiver_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lane_receiver_model
(
  // clock
  input wire logic clk_i,
  // lane pins
  input wire logic pos_i,
  input wire logic neg_i,
  input wire logic bclk_i,
  output logic ret_o,
  // receiver settings
  input wire logic swap_i,
  input wire logic [2:0] per_i,
  input wire logic flip_i,
  // one report per finished frame: length, high time, word
  output logic rep_v_o,
  output logic [25:0] rep_o
);
  logic bprev = 1'b0;
  logic armed = 1'b0;
  logic [7:0] len = 8'hff;
  logic [7:0] hi = 8'h00;
  logic [9:0] rx = 10'h000;
  initial rep_v_o = 1'b0;
  initial rep_o = '0;
  // returned byte clock on a direct net, inverted only when told to misbehave
  assign ret_o = bclk_i ^ flip_i;
  // frame starts on each byte clock rise, one sample per bit period
  always @(posedge clk_i)
  begin
    rep_v_o <= 1'b0;
    // pair lags the byte clock by one cycle: sample the first cycle of each bit
    if (len != 8'h00 && (len - 8'h01) % per_i == 0 && (len - 8'h01) / per_i < 10)
      rx[(len - 8'h01) / per_i] = swap_i ? neg_i : pos_i;
    if (bclk_i && !bprev)
    begin
      if (armed)
      begin
        rep_o <= {len, hi, rx};
        rep_v_o <= 1'b1;
      end
      armed <= 1'b1;
      len = 8'h00;
      hi = 8'h00;
      rx = 10'h000;
    end
    else if (len > 8'h3c)
      armed <= 1'b0; // long idle: drop the unfinished frame
    hi = hi + 8'(bclk_i);
    if (len != 8'hff)
      len = len + 8'h01;
    bprev <= bclk_i;
  end
endmodule // lane_receiver_model
`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import serdes_tx_lane_pkg::*;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  bus_req_s bus_i = '0;
  logic [9:0] tx_parallel_word_i = 10'h000;
  logic [31:0] rd_data_o;
  logic word_taken_o, bclk, ret, pos, neg, rep_v;
  logic swap = 1'b0;
  logic flip = 1'b0;
  logic rd_d = 1'b0;
  logic [2:0] per = 3'h1;
  logic [25:0] rep;
  analog_s analog_o;
  logic [31:0] rq[$], mq[$], wq[$];
  int err_count = 0, n_compared = 0, cyc = 0, nbits = 10;
  logic [10:0] swing_tab [8] = '{11'h07d, 11'h0fa, 11'h1f4, 11'h271, 11'h2ee, 11'h3e8,
    11'h465, 11'h4e2};
  logic [31:0] idle_cfg [6] = '{32'h0000_ff80, 32'h0000_0061, 32'h0000_0009, 32'h0000_000d,
    32'h0000_0011, 32'h0000_001d};

  // clock
  always #5 sys_clk_i = ~sys_clk_i;

  serdes_tx_lane_config serdes_tx_lane_config_i (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .bus_i(bus_i), .rd_data_o(rd_data_o), .tx_parallel_word_i(tx_parallel_word_i),
    .word_taken_o(word_taken_o), .tx_byte_clock_out_o(bclk), .tx_byte_clock_return_i(ret),
    .tx_pos_line_o(pos), .tx_neg_line_o(neg), .analog_o(analog_o));
  lane_receiver_model lane_receiver_model_i (.clk_i(sys_clk_i), .pos_i(pos), .neg_i(neg),
    .bclk_i(bclk), .ret_o(ret), .swap_i(swap), .per_i(per), .flip_i(flip),
    .rep_v_o(rep_v), .rep_o(rep));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic op(input bus_req_s r);
    @(posedge sys_clk_i);
    bus_i <= r;
    @(posedge sys_clk_i);
    bus_i <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    op({1'b1, 1'b0, a, d});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rq.push_back(e);
    mq.push_back(m);
    op({1'b0, 1'b1, a, 32'h0});
  endtask

  task automatic stop_lane;
    wr(8'h00, 32'h0);
    repeat (70) @(posedge sys_clk_i);
    wq.delete(); // frame cut short by the stop is never reported
  endtask

  task automatic tally_and_finish;
    if (err_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // read data one cycle after the strobe, receiver frame reports, hang guard
  always @(posedge sys_clk_i)
  begin
    if (rd_d)
      chk(rd_data_o & mq.pop_front(), rq.pop_front());
    rd_d <= bus_i.rd;
    if (rep_v)
      chk(32'(rep), wq.size() ? wq.pop_front() : 32'hffff_ffff);
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  // word source: note the sampled word, then offer a new random one
  always @(posedge sys_clk_i)
    if (word_taken_o === 1'b1)
    begin
      wq.push_back({8'(nbits * per), 8'(4 * per),
        nbits == 10 ? tx_parallel_word_i : {2'h0, tx_parallel_word_i[9:2]}});
      tx_parallel_word_i <= 10'($urandom);
    end

  // main sequence
  initial
  begin
    cfg_s c;
    logic act;
    void'($urandom(32'h0904));
    repeat (3) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    rd(8'h00, '1, 32'h0);
    chk(32'(analog_o), {6'h0, 11'h07d, 14'h0, 1'b0});
    wr(8'h00, '1);
    wr(8'h10, 32'h0);
    rd(8'h00, '1, 32'h0001_fffd);
    rd(8'h10, '1, 32'h0);
    rd(8'h04, '1, 32'h4);
    c = cfg_s'($urandom & 32'h0001_fffc);
    wr(8'h00, c);
    rd(8'h00, '1, c);
    // every swing and de-emphasis code, common mode toggled
    for (int i = 0; i < 16; i++)
    begin
      c = '0;
      c.swing = 3'(i);
      c.tx_emphasis_reduction = 4'(i);
      c.common_level_raise = i[0];
      wr(8'h00, c);
      repeat (2) @(posedge sys_clk_i);
      #1;
      chk(32'(analog_o), {6'h0, swing_tab[i % 8], 14'(i * 10000 / 21), i[0]});
    end
    // lane stays quiet when disabled or set to reserved codes
    for (int i = 0; i < 6; i++)
    begin
      wr(8'h00, idle_cfg[i]);
      act = 1'b0;
      repeat (50)
      begin
        @(posedge sys_clk_i);
        act = act | pos | neg | bclk | word_taken_o;
      end
      chk(32'(act), 32'h0);
      rd(8'h04, '1, i ? 32'h4 : 32'h0);
    end
    // every width, rate and polarity with live random words
    for (int w = 0; w < 2; w++)
      for (int r = 0; r < 3; r++)
        for (int s = 0; s < 2; s++)
        begin
          nbits = w ? 8 : 10;
          per <= 3'(1 << r);
          swap <= s[0];
          c = '0;
          c.transmitter_on = 1'b1;
          c.parallel_width_select = 3'(w);
          c.rate = 2'(r);
          c.pair_polarity_swap = s[0];
          c.swing = 3'($urandom);
          wr(8'h00, c);
          repeat (5 * nbits * (1 << r) + 20) @(posedge sys_clk_i);
          stop_lane();
        end
    // fixed phase: direct return is clean, inverted return is flagged
    per <= 3'h1;
    swap <= 1'b0;
    nbits = 10;
    wr(8'h00, 32'h0001_0001);
    repeat (30) @(posedge sys_clk_i);
    rd(8'h04, 32'hffff_fffe, 32'h0);
    flip <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    rd(8'h04, 32'hffff_fffe, 32'h2);
    flip <= 1'b0;
    stop_lane();
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
